// >>> power_monitor_model.sv
`timescale 1ns/1ps
`default_nettype none
module power_monitor_model #(
  parameter int LOCK_DLY = 40,
  parameter int PARK_DLY = 5
) (
  input  wire logic clk,
  input  wire logic pos_cmd,
  input  wire logic warn_cmd,
  input  wire logic pll_power_down,
  input  wire logic park_req,
  output logic      power_on_sense_input,
  output logic      supply_warning_input,
  output logic      dmd_link_pll_lock,
  output logic      mirrors_parked
);
  int lock_cnt;
  int park_cnt;
  // sense stays low until the bench says supplies are good
  always @(posedge clk) begin
    power_on_sense_input <= pos_cmd;
    supply_warning_input <= warn_cmd;
  end
  // lock only after settling; lost at once on power-down
  always @(posedge clk) begin
    if (pll_power_down) begin
      lock_cnt          <= 0;
      dmd_link_pll_lock <= 1'b0;
    end else if (lock_cnt < LOCK_DLY) begin
      lock_cnt <= lock_cnt + 1;
    end else begin
      dmd_link_pll_lock <= 1'b1;
    end
  end
  // mirrors take a few cycles to settle after the park request
  always @(posedge clk) begin
    if (!park_req) begin
      park_cnt       <= 0;
      mirrors_parked <= 1'b0;
    end else if (park_cnt < PARK_DLY) begin
      park_cnt <= park_cnt + 1;
    end else begin
      mirrors_parked <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> reset_seq_pkg.sv
package reset_seq_pkg;

  localparam int CLK_KHZ       = 40000;
  localparam int LOCK_WAIT_MS  = 60;
  localparam int LOCK_WAIT_CYC = CLK_KHZ * LOCK_WAIT_MS;
  localparam int CNT_W         = 22;
  localparam int GPIO_N        = 9;
  localparam int SYNC_N        = 3;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int RATE_W = 8;

  localparam logic [ADDR_W-1:0] OFS_CTRL     = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_DCG_RATE = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_DMD_RATE = 4'hC;

  localparam logic [RATE_W-1:0] RATE_RST = 8'h00;

  // synchroniser lanes
  localparam int SY_POS  = 0;
  localparam int SY_WARN = 1;
  localparam int SY_LOCK = 2;

  typedef enum logic [1:0] {
    CAUSE_POWER = 2'h0,
    CAUSE_WDOG  = 2'h1,
    CAUSE_WARN  = 2'h2
  } cause_t;

  typedef enum logic [4:0] {
    ST_OFF    = 5'h01,
    ST_WAIT   = 5'h02,
    ST_SYSRST = 5'h04,
    ST_RUN    = 5'h08,
    ST_PARK   = 5'h10
  } state_t;

  // control word, bit 4 down to bit 0
  typedef struct packed {
    logic core_rel;
    logic lvds_rel;
    logic ext_rel;
    logic div_run;
    logic pll_en;
  } ctrl_t;

  localparam ctrl_t CTRL_RST = 5'h00;

  // status word, bit 4 down to bit 0
  typedef struct packed {
    cause_t cause;
    logic   dmd_set;
    logic   dcg_set;
    logic   lock;
  } status_t;

endpackage

// >>> reset_sequencer.sv
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module reset_sequencer
  import reset_seq_pkg::*;
#(
  parameter int LOCK_CYC = LOCK_WAIT_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              power_on_sense_input,
  input  wire logic              supply_warning_input,
  input  wire logic              dmd_link_pll_lock,
  input  wire logic              watchdog_timeout,
  input  wire logic              mirrors_parked,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  output logic                   primary_system_pll_reset_b,
  output logic                   normal_power_mode,
  output logic                   cpu_reset_b,
  output logic                   periph_reset_b,
  output logic                   core_other_reset_b,
  output logic                   cpu_full_rate,
  output logic                   boot_from_flash,
  output logic      [GPIO_N-1:0] gpio_force_hiz,
  output logic                   dmd_link_pll_power_down,
  output logic                   dmd_div_reset_b,
  output logic                   dmd_clk_en,
  output logic      [RATE_W-1:0] dcg_rate,
  output logic      [RATE_W-1:0] dmd_rate,
  output logic                   lvds_power_down,
  output logic                   lvds_out_en,
  output logic                   lvds_reset_b,
  output logic                   ext_reset_b,
  output logic                   park_req
);

  logic [SYNC_N-1:0] s1_q;
  logic [SYNC_N-1:0] s2_q;
  logic [SYNC_N-1:0] s3_q;
  logic [SYNC_N-1:0] f_q;
  logic [SYNC_N-1:0] raw;
  logic              pos_f;
  logic              warn_ok;
  logic              lock_f;
  state_t            state_q;
  state_t            state_d;
  logic [CNT_W-1:0]  cnt_q;
  logic              wait_done;
  ctrl_t             ctrl_q;
  ctrl_t             wr_ctrl;
  logic              dcg_set_q;
  logic              dmd_set_q;
  cause_t            cause_q;
  status_t           status;
  logic              fw_clear;
  logic              wr_hit_ctrl;

  assign raw = {dmd_link_pll_lock, supply_warning_input, power_on_sense_input};

  // pin inputs: three stages, accept a level once stages two and three agree
  generate
    for (genvar i = 0; i < SYNC_N; i++) begin : g_sync
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          s1_q[i] <= 1'b0;
          s2_q[i] <= 1'b0;
          s3_q[i] <= 1'b0;
          f_q[i]  <= 1'b0;
        end else begin
          s1_q[i] <= raw[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          if (s2_q[i] == s3_q[i]) begin
            f_q[i] <= s3_q[i];
          end
        end
      end
    end
  endgenerate

  assign pos_f   = f_q[SY_POS];
  assign warn_ok = f_q[SY_WARN];
  assign lock_f  = f_q[SY_LOCK];

  assign wait_done = (cnt_q == CNT_W'(LOCK_CYC - 1));

  // sequencer; power loss beats warning, warning beats watchdog
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_OFF: begin
        if (pos_f) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!pos_f) begin
          state_d = ST_OFF;
        end else if (wait_done) begin
          state_d = ST_SYSRST;
        end
      end
      ST_SYSRST: begin
        if (!pos_f) begin
          state_d = ST_OFF;
        end else if (warn_ok) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!pos_f) begin
          state_d = ST_OFF;
        end else if (!warn_ok) begin
          state_d = ST_PARK;
        end else if (watchdog_timeout) begin
          state_d = ST_SYSRST;
        end
      end
      ST_PARK: begin
        if (!pos_f) begin
          state_d = ST_OFF;
        end else if (mirrors_parked) begin
          state_d = ST_SYSRST;
        end
      end
      default: state_d = ST_OFF;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // 60 ms hold lets the primary PLL lock before internal resets drop
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
    end else if (state_q == ST_WAIT && !wait_done) begin
      cnt_q <= cnt_q + CNT_W'(1);
    end else begin
      cnt_q <= '0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cause_q <= CAUSE_POWER;
    end else if (state_q == ST_OFF) begin
      cause_q <= CAUSE_POWER;
    end else if (state_q == ST_PARK && state_d == ST_SYSRST) begin
      cause_q <= CAUSE_WARN;
    end else if (state_q == ST_RUN && state_d == ST_SYSRST) begin
      cause_q <= CAUSE_WDOG;
    end
  end

  // firmware state is wiped by any reset phase; parking keeps it
  assign fw_clear    = (state_q != ST_RUN) && (state_q != ST_PARK);
  assign wr_hit_ctrl = reg_wr && (reg_addr == OFS_CTRL);
  assign wr_ctrl     = ctrl_t'(reg_wdata[$bits(ctrl_t)-1:0]);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dcg_set_q <= 1'b0;
      dcg_rate  <= RATE_RST;
    end else if (fw_clear) begin
      dcg_set_q <= 1'b0;
      dcg_rate  <= RATE_RST;
    end else if (reg_wr && reg_addr == OFS_DCG_RATE && !ctrl_q.pll_en) begin
      dcg_set_q <= 1'b1;
      dcg_rate  <= reg_wdata[RATE_W-1:0];
    end
  end

  // DMD clock rates only take once the link PLL reports lock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dmd_set_q <= 1'b0;
      dmd_rate  <= RATE_RST;
    end else if (fw_clear) begin
      dmd_set_q <= 1'b0;
      dmd_rate  <= RATE_RST;
    end else if (reg_wr && reg_addr == OFS_DMD_RATE && lock_f && ctrl_q.pll_en) begin
      dmd_set_q <= 1'b1;
      dmd_rate  <= reg_wdata[RATE_W-1:0];
    end
  end

  // a set that skips a step is dropped; clears are always honoured
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= CTRL_RST;
    end else if (fw_clear) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_hit_ctrl) begin
      ctrl_q.pll_en   <= wr_ctrl.pll_en && (ctrl_q.pll_en || dcg_set_q);
      ctrl_q.div_run  <= wr_ctrl.div_run && wr_ctrl.pll_en
                         && (ctrl_q.div_run || (lock_f && dmd_set_q));
      ctrl_q.ext_rel  <= wr_ctrl.ext_rel && wr_ctrl.div_run && wr_ctrl.pll_en
                         && (ctrl_q.ext_rel || ctrl_q.div_run);
      ctrl_q.lvds_rel <= wr_ctrl.lvds_rel;
      ctrl_q.core_rel <= wr_ctrl.core_rel;
    end else if (!ctrl_q.pll_en) begin
      ctrl_q.div_run <= 1'b0;
      ctrl_q.ext_rel <= 1'b0;
    end
  end

  assign status = '{cause: cause_q, dmd_set: dmd_set_q, dcg_set: dcg_set_q, lock: lock_f};

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OFS_CTRL:     reg_rdata <= DATA_W'(ctrl_q);
        OFS_STATUS:   reg_rdata <= DATA_W'(status);
        OFS_DCG_RATE: reg_rdata <= DATA_W'(dcg_rate);
        OFS_DMD_RATE: reg_rdata <= DATA_W'(dmd_rate);
        default:      reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // processor side of the chip
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      primary_system_pll_reset_b <= 1'b0;
      normal_power_mode          <= 1'b0;
      cpu_reset_b                <= 1'b0;
      periph_reset_b             <= 1'b0;
      cpu_full_rate              <= 1'b0;
      boot_from_flash            <= 1'b0;
      gpio_force_hiz             <= '1;
      park_req                   <= 1'b0;
    end else begin
      primary_system_pll_reset_b <= (state_q != ST_OFF);
      normal_power_mode          <= (state_q != ST_OFF);
      cpu_reset_b                <= (state_q == ST_RUN) || (state_q == ST_PARK);
      periph_reset_b             <= (state_q == ST_RUN) || (state_q == ST_PARK);
      cpu_full_rate              <= (state_q != ST_OFF);
      boot_from_flash            <= 1'b1;
      gpio_force_hiz             <= {GPIO_N{fw_clear}};
      park_req                   <= (state_q == ST_PARK);
    end
  end

  // link side stays dark until firmware walks it up
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      core_other_reset_b      <= 1'b0;
      dmd_link_pll_power_down <= 1'b1;
      dmd_div_reset_b         <= 1'b0;
      dmd_clk_en              <= 1'b0;
      lvds_power_down         <= 1'b1;
      lvds_out_en             <= 1'b0;
      lvds_reset_b            <= 1'b0;
      ext_reset_b             <= 1'b0;
    end else begin
      core_other_reset_b      <= ctrl_q.core_rel;
      dmd_link_pll_power_down <= !ctrl_q.pll_en;
      dmd_div_reset_b         <= ctrl_q.div_run;
      dmd_clk_en              <= ctrl_q.div_run;
      lvds_power_down         <= !ctrl_q.lvds_rel;
      lvds_out_en             <= ctrl_q.lvds_rel;
      lvds_reset_b            <= ctrl_q.lvds_rel;
      ext_reset_b             <= ctrl_q.ext_rel;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  a_pll_hold_off: assert property (
    state_q == ST_OFF |=> !primary_system_pll_reset_b && !cpu_reset_b)
    else $error("pll or cpu reset released while power sense low");

  a_lock_wait_end: assert property (
    (state_q == ST_WAIT && pos_f && wait_done) |=> state_q == ST_SYSRST)
    else $error("lock hold did not end in system reset");

  a_lock_wait_early: assert property (
    (state_q == ST_WAIT && !wait_done) |=> state_q != ST_SYSRST)
    else $error("lock hold cut short");

  a_pll_survives: assert property (
    (state_q == ST_SYSRST && pos_f) |=> primary_system_pll_reset_b ##1 primary_system_pll_reset_b)
    else $error("primary pll reset by a system reset");

  a_reset_default: assert property (
    state_q == ST_SYSRST |=> (&gpio_force_hiz) ##1 (dmd_link_pll_power_down && !dmd_clk_en
                                  && !ext_reset_b && lvds_power_down && !lvds_reset_b))
    else $error("post reset defaults not applied");

  a_run_release: assert property (
    (state_q == ST_RUN && state_d == ST_RUN) |=> cpu_reset_b && periph_reset_b
                                                 && cpu_full_rate && boot_from_flash)
    else $error("processor not released at full rate");

  a_wdog_reset: assert property (
    (state_q == ST_RUN && pos_f && warn_ok && watchdog_timeout) |=> state_q == ST_SYSRST
                                                                    ##1 cause_q == CAUSE_WDOG)
    else $error("watchdog did not reset the system");

  a_warn_parks: assert property (
    (state_q == ST_RUN && pos_f && !warn_ok) |=> state_q == ST_PARK ##1 park_req)
    else $error("supply warning did not park mirrors");

  a_park_first: assert property (
    (state_q == ST_PARK && pos_f && !mirrors_parked) |=> state_q == ST_PARK)
    else $error("reset before mirrors parked");

  a_pll_en_order: assert property (
    $rose(ctrl_q.pll_en) |-> dcg_set_q && !ctrl_q.div_run)
    else $error("link pll enabled before rate set");

  a_div_order: assert property (
    $rose(ctrl_q.div_run) |-> $past(lock_f) && $past(dmd_set_q))
    else $error("dividers released before lock");

  a_ext_last: assert property (
    $rose(ctrl_q.ext_rel) |-> $past(ctrl_q.div_run) ##1 ext_reset_b && dmd_clk_en)
    else $error("external reset released too early");

endmodule
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import reset_seq_pkg::*;
  localparam int LCYC = 16;
  typedef struct packed {
    logic        lk;
    logic [3:0]  a;
    logic [7:0]  d;
    logic [4:0]  o;
    logic [7:0]  ddr_clock_generator;
    logic [7:0]  dmd;
  } row_t;
  logic clk = 1'b0, rst_b = 1'b0, wdog = 1'b0, pos_cmd = 1'b0, warn_cmd = 1'b1;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic [ADDR_W-1:0] reg_addr = 4'h0;
  logic [DATA_W-1:0] reg_wdata = 32'h0, rdata, rd_v;
  logic pos, warn, lock, parked, pll_rst_b, npm, cpu_b, per_b, core_b, full, boot;
  logic pd, div_b, clk_en, lvds_pd, lvds_oe, lvds_b, ext_b, park;
  logic [GPIO_N-1:0] hiz;
  logic [RATE_W-1:0] ddr_clock_generator, dmd;
  logic [4:0] mon;
  int err_count = 0, checks_done = 0, n;
  row_t rows [12] = '{
    '{1'b0, 4'hC, 8'h11, 5'h00, 8'h00, 8'h00},
    '{1'b0, 4'h0, 8'h01, 5'h00, 8'h00, 8'h00},
    '{1'b0, 4'h8, 8'h5A, 5'h00, 8'h5A, 8'h00},
    '{1'b0, 4'h0, 8'h01, 5'h01, 8'h5A, 8'h00},
    '{1'b0, 4'h8, 8'h33, 5'h01, 8'h5A, 8'h00},
    '{1'b0, 4'hC, 8'h22, 5'h01, 8'h5A, 8'h00},
    '{1'b1, 4'h0, 8'h07, 5'h01, 8'h5A, 8'h00},
    '{1'b0, 4'hC, 8'h22, 5'h01, 8'h5A, 8'h22},
    '{1'b0, 4'h0, 8'h07, 5'h03, 8'h5A, 8'h22},
    '{1'b0, 4'h0, 8'h07, 5'h07, 8'h5A, 8'h22},
    '{1'b0, 4'h0, 8'h1F, 5'h1F, 8'h5A, 8'h22},
    '{1'b0, 4'h0, 8'h1E, 5'h18, 8'h5A, 8'h22}};
  assign mon = {lock, park, cpu_b, pll_rst_b, hiz[0]};
  always #12.5 clk = ~clk;
  power_monitor_model u_mon (.clk(clk), .pos_cmd(pos_cmd), .warn_cmd(warn_cmd),
    .pll_power_down(pd), .park_req(park), .power_on_sense_input(pos),
    .supply_warning_input(warn), .dmd_link_pll_lock(lock), .mirrors_parked(parked));
  reset_sequencer #(.LOCK_CYC(LCYC)) u_dut (.clk(clk), .rst_b(rst_b),
    .power_on_sense_input(pos), .supply_warning_input(warn), .dmd_link_pll_lock(lock),
    .watchdog_timeout(wdog), .mirrors_parked(parked), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
    .primary_system_pll_reset_b(pll_rst_b), .normal_power_mode(npm), .cpu_reset_b(cpu_b),
    .periph_reset_b(per_b), .core_other_reset_b(core_b), .cpu_full_rate(full),
    .boot_from_flash(boot), .gpio_force_hiz(hiz), .dmd_link_pll_power_down(pd),
    .dmd_div_reset_b(div_b), .dmd_clk_en(clk_en), .dcg_rate(ddr_clock_generator), .dmd_rate(dmd),
    .lvds_power_down(lvds_pd), .lvds_out_en(lvds_oe), .lvds_reset_b(lvds_b),
    .ext_reset_b(ext_b), .park_req(park));
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_bit(input int i, input logic v);
    int k;
    k = 0;
    while (mon[i] !== v && k < 400) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k >= 400) begin
      err_count++;
      $display("ERROR %0t wait on bit %0d for %h", $time, i, v);
      end_of_test();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = rdata;
  endtask
  // common post-reset picture of the sequencer outputs
  function automatic logic [31:0] post();
    return {20'h0, npm, cpu_b, per_b, core_b, full, boot, ext_b, lvds_oe, lvds_b,
            clk_en, pd, lvds_pd};
  endfunction
  task automatic settle_run(input logic [1:0] cause);
    wait_bit(2, 1'b1);
    chk_word(post(), 32'hEC3);
    chk_word({23'h0, hiz}, 32'h0);
    rd(OFS_STATUS, rd_v);
    chk_word({30'h0, rd_v[4:3]}, {30'h0, cause});
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk_word({19'h0, hiz, ext_b, pd, lvds_pd, boot}, {19'h0, 9'h1FF, 4'h6});
    repeat (3) @(posedge clk);
    pos_cmd <= 1'b1;
    settle_run(CAUSE_POWER);
    foreach (rows[i]) begin
      if (rows[i].lk) begin
        wait_bit(4, 1'b1);
        repeat (6) @(posedge clk);
        rd(OFS_STATUS, rd_v);
        chk_word({31'h0, rd_v[0]}, 32'h1);
      end
      wr(rows[i].a, {24'h0, rows[i].d});
      repeat (3) @(posedge clk);
      #1;
      chk_word({11'h0, core_b, lvds_b, ext_b, div_b, !pd, ddr_clock_generator, dmd},
               {11'h0, rows[i].o, rows[i].ddr_clock_generator, rows[i].dmd});
    end
    repeat (6) @(posedge clk);
    wr(OFS_STATUS, 32'hFFFF_FFFF);
    rd(OFS_STATUS, rd_v);
    chk_word(rd_v, 32'h6);
    rd(4'h2, rd_v);
    chk_word(rd_v, 32'h0);
    rd(OFS_DCG_RATE, rd_v);
    chk_word(rd_v, 32'h5A);
    rd(OFS_CTRL, rd_v);
    chk_word(rd_v, 32'h18);
    rd(OFS_DMD_RATE, rd_v);
    chk_word(rd_v, 32'h22);
    @(posedge clk) wdog <= 1'b1;
    @(posedge clk) wdog <= 1'b0;
    wait_bit(0, 1'b1);
    chk_word({31'h0, pll_rst_b}, 32'h1);
    settle_run(CAUSE_WDOG);
    warn_cmd <= 1'b0;
    wait_bit(3, 1'b1);
    chk_word({22'h0, cpu_b, hiz}, 32'h200);
    wait_bit(0, 1'b1);
    repeat (20) @(posedge clk);
    #1;
    chk_word({30'h0, hiz[0], pll_rst_b}, 32'h3);
    warn_cmd <= 1'b1;
    settle_run(CAUSE_WARN);
    pos_cmd <= 1'b0;
    wait_bit(1, 1'b0);
    chk_word({31'h0, npm}, 32'h0);
    pos_cmd <= 1'b1;
    wait_bit(1, 1'b1);
    n = 0;
    while (cpu_b !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk_word({31'h0, n >= LCYC && n <= LCYC + 8}, 32'h1);
    settle_run(CAUSE_POWER);
    end_of_test();
  end
endmodule
`default_nettype wire
